// File: pci_defs.svh
`ifndef PCI_DEFS_SVH
`define PCI_DEFS_SVH

`define PCI_ADDR_W        4
`define PCI_OFF_A_RISE    4'h0
`define PCI_OFF_A_FALL    4'h1
`define PCI_OFF_A_FLAG    4'h2
`define PCI_OFF_B_RISE    4'h3
`define PCI_OFF_B_FALL    4'h4
`define PCI_OFF_B_FLAG    4'h5
`define PCI_OFF_CTRL      4'h6
`define PCI_OFF_STAT      4'h7
`define PCI_OFF_IRQ_STAT  4'h8
`define PCI_OFF_IRQ_MASK  4'h9
`define PCI_A_MASK        8'h3f
`define PCI_B_MASK        8'hf0
`define PCI_RESET_VAL     8'h00
`define PCI_CTRL_GEN_BIT  0
`define PCI_EV_A_BIT      0
`define PCI_EV_B_BIT      1
`define PCI_EV_W          2

`endif

// File: pci_pkg.sv
`include "pci_defs.svh"
package pci_pkg;
  typedef struct packed {
    logic [`PCI_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
    logic                   wr;
    logic                   rd;
  } pci_bus_req_t;

  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] flag;
  } pci_port_cfg_t;
endpackage

// File: pci_top.sv
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "pci_defs.svh"
module pci_top (
  input  wire logic                 MCLK,
  input  wire logic                 RST_N,
  input  wire pci_pkg::pci_bus_req_t BUS_REQ,
  output logic [7:0]                RDATA,
  input  wire logic [7:0]           PORT_A_PIN,
  input  wire logic [7:0]           PORT_B_PIN,
  input  wire logic                 SLEEP,
  output logic                      CHANGE_IRQ,
  output logic                      WAKE,
  output logic                      CHANGE_IRQ_SUMMARY_FLAG,
  output logic                      IRQ
);
  import pci_pkg::*;

  logic [7:0]          sync1_a_ff, sync2_a_ff, prev_a_ff;
  logic [7:0]          sync1_b_ff, sync2_b_ff, prev_b_ff;
  logic [2:0]          primed_ff;
  pci_port_cfg_t       cfg_a_ff, cfg_b_ff;
  logic                gen_ff;
  logic [`PCI_EV_W-1:0] ev_stat_ff, ev_mask_ff;
  logic [7:0]          hit_a, hit_b;
  logic [7:0]          nxt_flag_a, nxt_flag_b;
  logic [`PCI_EV_W-1:0] nxt_ev_stat;
  logic [7:0]          nxt_rdata;
  logic                any_flag;

  // Two-stage synchronisers, then a third stage to compare against
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_a_ff <= 8'h00;
      sync2_a_ff <= 8'h00;
      prev_a_ff  <= 8'h00;
      sync1_b_ff <= 8'h00;
      sync2_b_ff <= 8'h00;
      prev_b_ff  <= 8'h00;
      primed_ff  <= 3'h0;
    end else begin
      sync1_a_ff <= PORT_A_PIN;
      sync2_a_ff <= sync1_a_ff;
      prev_a_ff  <= sync2_a_ff;
      sync1_b_ff <= PORT_B_PIN;
      sync2_b_ff <= sync1_b_ff;
      prev_b_ff  <= sync2_b_ff;
      primed_ff  <= {primed_ff[1:0], 1'b1};
    end
  end

  // Edge qualification; the first three cycles after reset only fill the pipe
  always_comb begin
    hit_a = ((sync2_a_ff & ~prev_a_ff & cfg_a_ff.rise) |
             (~sync2_a_ff & prev_a_ff & cfg_a_ff.fall)) & `PCI_A_MASK;
    hit_b = ((sync2_b_ff & ~prev_b_ff & cfg_b_ff.rise) |
             (~sync2_b_ff & prev_b_ff & cfg_b_ff.fall)) & `PCI_B_MASK;
    if (!primed_ff[2]) begin
      hit_a = 8'h00;
      hit_b = 8'h00;
    end
  end

  // Flag write stores data, then any edge this cycle sets over it
  always_comb begin
    nxt_flag_a = cfg_a_ff.flag;
    nxt_flag_b = cfg_b_ff.flag;
    if (BUS_REQ.wr && BUS_REQ.addr == `PCI_OFF_A_FLAG) begin
      nxt_flag_a = BUS_REQ.wdata & `PCI_A_MASK;
    end
    if (BUS_REQ.wr && BUS_REQ.addr == `PCI_OFF_B_FLAG) begin
      nxt_flag_b = BUS_REQ.wdata & `PCI_B_MASK;
    end
    nxt_flag_a = nxt_flag_a | hit_a;
    nxt_flag_b = nxt_flag_b | hit_b;
  end

  // Flags, enable and control registers share one process: one struct, one driver
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_a_ff.flag <= `PCI_RESET_VAL;
      cfg_b_ff.flag <= `PCI_RESET_VAL;
      cfg_a_ff.rise <= `PCI_RESET_VAL;
      cfg_a_ff.fall <= `PCI_RESET_VAL;
      cfg_b_ff.rise <= `PCI_RESET_VAL;
      cfg_b_ff.fall <= `PCI_RESET_VAL;
      gen_ff        <= 1'b0;
      ev_mask_ff    <= '0;
    end else begin
      cfg_a_ff.flag <= nxt_flag_a;
      cfg_b_ff.flag <= nxt_flag_b;
      if (BUS_REQ.wr) begin
      if (BUS_REQ.addr == `PCI_OFF_A_RISE) begin
        cfg_a_ff.rise <= BUS_REQ.wdata & `PCI_A_MASK;
      end else if (BUS_REQ.addr == `PCI_OFF_A_FALL) begin
        cfg_a_ff.fall <= BUS_REQ.wdata & `PCI_A_MASK;
      end else if (BUS_REQ.addr == `PCI_OFF_B_RISE) begin
        cfg_b_ff.rise <= BUS_REQ.wdata & `PCI_B_MASK;
      end else if (BUS_REQ.addr == `PCI_OFF_B_FALL) begin
        cfg_b_ff.fall <= BUS_REQ.wdata & `PCI_B_MASK;
      end else if (BUS_REQ.addr == `PCI_OFF_CTRL) begin
        gen_ff <= BUS_REQ.wdata[`PCI_CTRL_GEN_BIT];
      end else if (BUS_REQ.addr == `PCI_OFF_IRQ_MASK) begin
        ev_mask_ff <= BUS_REQ.wdata[`PCI_EV_W-1:0];
      end
      end
    end
  end

  // Sticky per-port event status, write one to clear, set wins
  always_comb begin
    nxt_ev_stat = ev_stat_ff;
    if (BUS_REQ.wr && BUS_REQ.addr == `PCI_OFF_IRQ_STAT) begin
      nxt_ev_stat = ev_stat_ff & ~BUS_REQ.wdata[`PCI_EV_W-1:0];
    end
    nxt_ev_stat[`PCI_EV_A_BIT] = nxt_ev_stat[`PCI_EV_A_BIT] | (|hit_a);
    nxt_ev_stat[`PCI_EV_B_BIT] = nxt_ev_stat[`PCI_EV_B_BIT] | (|hit_b);
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ev_stat_ff <= '0;
    end else begin
      ev_stat_ff <= nxt_ev_stat;
    end
  end

  assign any_flag = (|nxt_flag_a) | (|nxt_flag_b);

  // Outputs, all registered, computed from next state so they track flags
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      CHANGE_IRQ_SUMMARY_FLAG <= 1'b0;
      CHANGE_IRQ              <= 1'b0;
      WAKE                    <= 1'b0;
      IRQ                     <= 1'b0;
    end else begin
      CHANGE_IRQ_SUMMARY_FLAG <= any_flag;
      CHANGE_IRQ              <= any_flag & gen_ff;
      WAKE                    <= any_flag & gen_ff & SLEEP;
      IRQ                     <= |(nxt_ev_stat & ev_mask_ff);
    end
  end

  // Read port, data one cycle after the strobe, unmapped reads zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (BUS_REQ.addr == `PCI_OFF_A_RISE) begin
      nxt_rdata = cfg_a_ff.rise;
    end else if (BUS_REQ.addr == `PCI_OFF_A_FALL) begin
      nxt_rdata = cfg_a_ff.fall;
    end else if (BUS_REQ.addr == `PCI_OFF_A_FLAG) begin
      nxt_rdata = cfg_a_ff.flag;
    end else if (BUS_REQ.addr == `PCI_OFF_B_RISE) begin
      nxt_rdata = cfg_b_ff.rise;
    end else if (BUS_REQ.addr == `PCI_OFF_B_FALL) begin
      nxt_rdata = cfg_b_ff.fall;
    end else if (BUS_REQ.addr == `PCI_OFF_B_FLAG) begin
      nxt_rdata = cfg_b_ff.flag;
    end else if (BUS_REQ.addr == `PCI_OFF_CTRL) begin
      nxt_rdata = {7'h00, gen_ff};
    end else if (BUS_REQ.addr == `PCI_OFF_STAT) begin
      nxt_rdata = {7'h00, (|cfg_a_ff.flag) | (|cfg_b_ff.flag)};
    end else if (BUS_REQ.addr == `PCI_OFF_IRQ_STAT) begin
      nxt_rdata = {6'h00, ev_stat_ff};
    end else if (BUS_REQ.addr == `PCI_OFF_IRQ_MASK) begin
      nxt_rdata = {6'h00, ev_mask_ff};
    end
    if (!BUS_REQ.rd) begin
      nxt_rdata = 8'h00;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= nxt_rdata;
    end
  end
endmodule // pci_top

// File: pci_assertions.sv
`timescale 1ns/1ps
module pci_assertions (
  input wire logic                  MCLK,
  input wire logic                  RST_N,
  input wire pci_pkg::pci_bus_req_t BUS_REQ,
  input wire logic [7:0]            RDATA,
  input wire logic [7:0]            PORT_A_PIN,
  input wire logic [7:0]            PORT_B_PIN,
  input wire logic                  SLEEP,
  input wire logic                  CHANGE_IRQ,
  input wire logic                  WAKE,
  input wire logic                  CHANGE_IRQ_SUMMARY_FLAG,
  input wire logic                  IRQ
);
  import pci_pkg::*;
  logic sum;
  assign sum = CHANGE_IRQ_SUMMARY_FLAG;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence rd_a;
    BUS_REQ.rd && BUS_REQ.addr <= 4'h2;
  endsequence
  sequence rd_b;
    BUS_REQ.rd && BUS_REQ.addr >= 4'h3 && BUS_REQ.addr <= 4'h5;
  endsequence
  a_unmapped_read: assert property (BUS_REQ.rd && BUS_REQ.addr > 4'h9 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_a_upper_zero: assert property (rd_a |=> RDATA[7:6] == 2'h0)
    else $error("port a upper bits set");
  a_b_lower_zero: assert property (rd_b |=> RDATA[3:0] == 4'h0)
    else $error("port b lower bits set");
  a_irq_gate: assert property (CHANGE_IRQ |-> sum)
    else $error("request without flag");
  a_wake_sleep: assert property (WAKE |-> CHANGE_IRQ && $past(SLEEP))
    else $error("wake without cause");
  a_flag_cause: assert property ($rose(sum) |-> $past(BUS_REQ.wr)
    || $past(PORT_A_PIN, 3) != $past(PORT_A_PIN, 4)
    || $past(PORT_B_PIN, 3) != $past(PORT_B_PIN, 4)) else $error("flag rose alone");
  a_flag_sticky: assert property ($fell(sum) |-> $past(BUS_REQ.wr))
    else $error("flag dropped alone");
  a_irq_drop: assert property ($fell(CHANGE_IRQ) |-> !sum
    || $past(BUS_REQ.wr) || $past(BUS_REQ.wr, 2)) else $error("request dropped");
endmodule // pci_assertions
bind pci_top pci_assertions pci_assertions_inst (.MCLK, .RST_N, .BUS_REQ, .RDATA,
  .PORT_A_PIN, .PORT_B_PIN, .SLEEP, .CHANGE_IRQ, .WAKE, .CHANGE_IRQ_SUMMARY_FLAG, .IRQ);

// File: pci_far_end.sv
`timescale 1ns/1ps
module pci_far_end (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] a_want,
  input  wire logic [7:0] b_want,
  input  wire logic       nap,
  input  wire logic       wake,
  output logic [7:0]      pin_a_ff,
  output logic [7:0]      pin_b_ff,
  output logic            sleep_ff
);
  // Pads follow the request one clock late
  always_ff @(posedge clk) begin
    pin_a_ff <= a_want;
    pin_b_ff <= b_want;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_ff <= 1'b0;
    end else begin
      sleep_ff <= nap && !wake;
    end
  end
endmodule // pci_far_end

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pci_pkg::*;
  typedef struct packed {logic [7:0] rise, fall, p0, p1, flg;} pci_row_t;
  logic         clk, rst_n, nap, sleep, irq_c, wake, sum, irq;
  logic [7:0]   rdata, a_want, b_want, pa, pb, v, seen;
  pci_bus_req_t req;
  int           bad_count, total_checks, cyc;
  pci_row_t     rows [5] = '{'{8'h3f, 8'h00, 8'h00, 8'h3f, 8'h3f},
    '{8'h3f, 8'h00, 8'h3f, 8'h00, 8'h00}, '{8'h00, 8'h15, 8'h3f, 8'h00, 8'h15},
    '{8'h0c, 8'h0c, 8'h04, 8'h08, 8'h0c}, '{8'hff, 8'hff, 8'h00, 8'hff, 8'h3f}};
  pci_top pci_top_inst (.MCLK(clk), .RST_N(rst_n), .BUS_REQ(req), .RDATA(rdata),
    .PORT_A_PIN(pa), .PORT_B_PIN(pb), .SLEEP(sleep), .CHANGE_IRQ(irq_c), .WAKE(wake),
    .CHANGE_IRQ_SUMMARY_FLAG(sum), .IRQ(irq));
  pci_far_end pci_far_end_inst (.clk, .rst_n, .a_want, .b_want, .nap, .wake,
    .pin_a_ff(pa), .pin_b_ff(pb), .sleep_ff(sleep));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {rst_n, nap, a_want, b_want, req, cyc, bad_count, total_checks} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd(i[3:0], v);
      chk("reset value", 8'h00, v);
    end
    $display("reset test done");
    wr(4'h6, 8'h01);
    foreach (rows[i]) begin
      wr(4'h0, rows[i].rise);
      wr(4'h1, rows[i].fall);
      a_want <= rows[i].p0;
      repeat (4) @(posedge clk);
      wr(4'h2, 8'h00);
      a_want <= rows[i].p1;
      repeat (4) @(posedge clk);
      rd(4'h2, v);
      chk("port a flags", rows[i].flg, v);
      chk("sum and request", {6'h0, {2{|rows[i].flg}}}, {6'h0, sum, irq_c});
      $display("row %0d done", i);
    end
    wr(4'h3, 8'hff);
    wr(4'h4, 8'hff);
    b_want <= 8'hff;
    rd(4'h3, v);
    chk("b rise", 8'hf0, v);
    rd(4'h4, v);
    chk("b fall", 8'hf0, v);
    rd(4'h0, v);
    chk("a rise", 8'h3f, v);
    rd(4'h5, v);
    chk("b flags", 8'hf0, v);
    wr(4'h9, 8'h02);
    repeat (2) @(posedge clk);
    chk("irq masked in", 8'h01, {7'h0, irq});
    wr(4'h9, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq masked out", 8'h00, {7'h0, irq});
    wr(4'h9, 8'h02);
    wr(4'h8, 8'h02);
    repeat (2) @(posedge clk);
    chk("irq cleared", 8'h00, {7'h0, irq});
    rd(4'h8, v);
    chk("event status", 8'h01, v);
    wr(4'hc, 8'hff);
    rd(4'hc, v);
    chk("unmapped", 8'h00, v);
    $display("port b and irq test done");
    wr(4'h6, 8'h00);
    wr(4'h5, 8'h00);
    b_want <= 8'h00;
    repeat (4) @(posedge clk);
    rd(4'h5, v);
    chk("flags disabled", 8'hf0, v);
    chk("request disabled", 8'h00, {7'h0, irq_c});
    wr(4'h2, 8'h00);
    a_want <= 8'hfe;
    repeat (2) @(posedge clk);
    wr(4'h2, 8'h00);
    rd(4'h2, v);
    chk("set beats clear", 8'h01, v);
    wr(4'h6, 8'h01);
    wr(4'h2, 8'h00);
    wr(4'h5, 8'h00);
    nap <= 1'b1;
    repeat (3) @(posedge clk);
    a_want <= 8'hff;
    for (int n = 0; n < 20 && wake !== 1'b1; n++) @(posedge clk);
    chk("wake", 8'h01, {7'h0, wake});
    nap <= 1'b0;
    rd(4'h2, v);
    chk("sleep flags", 8'h01, v);
    rd(4'h7, v);
    chk("summary status", 8'h01, v);
    $display("sleep test done");
    seen = v;
    rd(4'h2, seen);
    a_want <= 8'hfd;
    repeat (5) @(posedge clk);
    rd(4'h2, v);
    wr(4'h2, v & ~seen);
    rd(4'h2, v);
    chk("masked clear", 8'h02, v);
    $display("masked clear test done");
    tally_and_finish();
  end
endmodule // tb_top
